// >>> sac_pkg.sv
// constants of the serial converter control block, and its two-entry result buffer
package sac_pkg;
  localparam int unsigned SAC_RES_BITS = 10;
  localparam int unsigned SAC_CLK_PERIOD_NS = 8;
  localparam int unsigned SAC_CONV_TIME_NS = 9000;
  localparam int unsigned SAC_CONV_CYCLES = SAC_CONV_TIME_NS / SAC_CLK_PERIOD_NS;
  localparam int unsigned SAC_STEP_CYCLES = (SAC_CONV_CYCLES - 3) / (SAC_RES_BITS + 1);
  localparam int unsigned SAC_CNT_W = 11;
  localparam logic [10:0] SAC_CNT_RESET = 11'h000;
  localparam logic [10:0] SAC_EOC_AT = 11'(SAC_CONV_CYCLES - 3);
  localparam logic [10:0] SAC_STEP_LAST = 11'(SAC_STEP_CYCLES - 1);
  localparam logic [3:0] SAC_BIT_MSB = 4'h9;
  localparam logic [9:0] SAC_RESULT_RESET = 10'h000;
  localparam int unsigned SAC_BUF_DEPTH = 2;
  typedef enum logic [1:0] {SAC_IDLE, SAC_CONV, SAC_PUSH, SAC_READ} sac_state_t;
endpackage

// two-entry buffer with valid and ready on both sides
module sac_buf #(
  parameter int unsigned WIDTH = 10,
  parameter int unsigned DEPTH = sac_pkg::SAC_BUF_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  if (DEPTH != 2 || WIDTH < 1) begin : g_depth_check
    $error("sac_buf: depth must be 2");
  end
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic [1:0] count_reg;
  logic push;
  logic pop;
  assign in_ready = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else if (ce) begin
      if (push) wr_ptr_reg <= ~wr_ptr_reg;
      if (pop) rd_ptr_reg <= ~rd_ptr_reg;
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end
  always_ff @(posedge clk) begin
    if (ce && push) mem_reg[wr_ptr_reg] <= in_data;
  end
endmodule // sac_buf

// >>> sac_top.sv
// control, conversion sequencing and serial readout of the 10-bit converter
// Operation
// RL1: select falling starts conversion, switches to hold
// RL2: select high keeps data output tri-stated
// RL3: output changes only on serial clock falls
// RL4: marker high bit, then result MSB first
// RL5: result sent as plain straight binary
// RL6: power-down low means shutdown, no conversions
// RL7: power-down high or floating means operational
// RL8: high enables internal reference, floating disables
// RL9: whole conversion finishes within 9 us
// RL10: host keeps select high 1.5 us acquisition
// RL11: host serial clock at most 2.1 MHz
// RL12: host holds clock low 50 ns before select
// RL13: host waits for marker before rising clock
// RL14: conversion end returns stage to tracking
// RL15: select fall drives low until marker high
// RL16: host keeps clock still during conversion
// RL17: 13 falls read all; extra give zeros
// RL18: early select rise abandons readout cleanly
module sac_top #(
  parameter int unsigned RES_BITS = sac_pkg::SAC_RES_BITS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic pd_level_low,
  input wire logic pd_level_high,
  input wire logic cmp_in,
  output logic dout_o,
  output logic dout_oe,
  output logic hold_o,
  output logic [RES_BITS-1:0] dac_code_o,
  output logic shutdown_o,
  output logic int_ref_en_o
);
  if (RES_BITS != 10) begin : g_res_check
    $error("sac_top: resolution must be 10");
  end
  // pins come from outside the clock domain: two flops first
  logic [1:0] cs_sync_reg;
  logic [1:0] sclk_sync_reg;
  logic [1:0] pdl_sync_reg;
  logic [1:0] pdh_sync_reg;
  logic [1:0] cmp_sync_reg;
  logic cs_prev_reg;
  logic sclk_prev_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      cs_sync_reg <= 2'h3;
      sclk_sync_reg <= 2'h0;
      pdl_sync_reg <= 2'h0;
      pdh_sync_reg <= 2'h0;
      cmp_sync_reg <= 2'h0;
      cs_prev_reg <= 1'b1;
      sclk_prev_reg <= 1'b0;
    end else if (ce) begin
      cs_sync_reg <= {cs_sync_reg[0], cs_n};
      sclk_sync_reg <= {sclk_sync_reg[0], sclk};
      pdl_sync_reg <= {pdl_sync_reg[0], pd_level_low};
      pdh_sync_reg <= {pdh_sync_reg[0], pd_level_high};
      cmp_sync_reg <= {cmp_sync_reg[0], cmp_in};
      cs_prev_reg <= cs_sync_reg[1];
      sclk_prev_reg <= sclk_sync_reg[1];
    end
  end
  logic cs_s;
  logic cs_fall;
  logic sclk_fall;
  logic shut;
  assign cs_s = cs_sync_reg[1];
  assign cs_fall = cs_prev_reg && !cs_s;
  assign sclk_fall = sclk_prev_reg && !sclk_sync_reg[1];
  // three-level pin seen as two detector levels; middle means neither
  assign shut = pdl_sync_reg[1];
  assign shutdown_o = shut; // [RL6]
  assign int_ref_en_o = !shut && pdh_sync_reg[1]; // [RL7] [RL8]

  sac_pkg::sac_state_t state_reg;
  logic [10:0] conv_cnt_reg;
  logic [10:0] step_cnt_reg;
  logic [3:0] bit_idx_reg;
  logic [RES_BITS-1:0] sar_reg;
  logic [RES_BITS:0] shift_reg;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [RES_BITS-1:0] buf_out_data;
  logic sar_done;

  function automatic logic [RES_BITS-1:0] trial_bit(input logic [3:0] idx);
    trial_bit = RES_BITS'(1) << idx;
  endfunction

  assign sar_done = (conv_cnt_reg >= sac_pkg::SAC_EOC_AT);

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= sac_pkg::SAC_IDLE;
    end else if (ce) begin
      if (cs_s) begin
        state_reg <= sac_pkg::SAC_IDLE; // [RL18]
      end else begin
        case (state_reg)
          sac_pkg::SAC_IDLE: if (cs_fall && !shut) state_reg <= sac_pkg::SAC_CONV; // [RL1] [RL6]
          sac_pkg::SAC_CONV: if (sar_done) state_reg <= sac_pkg::SAC_PUSH;
          // waits here while the buffer is full: back-pressure stalls the converter
          sac_pkg::SAC_PUSH: if (buf_in_ready) state_reg <= sac_pkg::SAC_READ;
          sac_pkg::SAC_READ: state_reg <= sac_pkg::SAC_READ;
          default: state_reg <= sac_pkg::SAC_IDLE;
        endcase
      end
    end
  end

  // conversion timer and successive approximation
  always_ff @(posedge clk) begin
    if (rst) begin
      conv_cnt_reg <= sac_pkg::SAC_CNT_RESET;
      step_cnt_reg <= sac_pkg::SAC_CNT_RESET;
      bit_idx_reg <= sac_pkg::SAC_BIT_MSB;
      sar_reg <= sac_pkg::SAC_RESULT_RESET;
    end else if (ce) begin
      if (state_reg != sac_pkg::SAC_CONV) begin
        conv_cnt_reg <= sac_pkg::SAC_CNT_RESET;
        step_cnt_reg <= sac_pkg::SAC_CNT_RESET;
        bit_idx_reg <= sac_pkg::SAC_BIT_MSB;
        if (state_reg == sac_pkg::SAC_IDLE) sar_reg <= sac_pkg::SAC_RESULT_RESET;
      end else if (!sar_done) begin
        conv_cnt_reg <= conv_cnt_reg + 11'h001; // [RL9]
        if (step_cnt_reg == sac_pkg::SAC_STEP_LAST) begin
          step_cnt_reg <= sac_pkg::SAC_CNT_RESET;
          // first step is settling; decisions fill bits msb down to lsb
          if (conv_cnt_reg > sac_pkg::SAC_STEP_LAST && bit_idx_reg != 4'hf) begin
            if (cmp_sync_reg[1]) sar_reg <= sar_reg | trial_bit(bit_idx_reg); // [RL5]
            bit_idx_reg <= bit_idx_reg - 4'h1;
          end
        end else begin
          step_cnt_reg <= step_cnt_reg + 11'h001;
        end
      end
    end
  end
  assign dac_code_o = (state_reg == sac_pkg::SAC_CONV && bit_idx_reg != 4'hf) ?
    (sar_reg | trial_bit(bit_idx_reg)) : sar_reg;
  assign hold_o = (state_reg == sac_pkg::SAC_CONV); // [RL1] [RL14]

  logic buf_pop;
  logic buf_push;
  assign buf_push = (state_reg == sac_pkg::SAC_PUSH) && !cs_s;
  assign buf_pop = buf_out_valid && (state_reg != sac_pkg::SAC_PUSH);

  sac_buf #(.WIDTH(RES_BITS), .DEPTH(sac_pkg::SAC_BUF_DEPTH)) u_buf (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .in_valid(buf_push),
    .in_ready(buf_in_ready),
    .in_data(sar_reg),
    .out_valid(buf_out_valid),
    .out_ready(buf_pop),
    .out_data(buf_out_data)
  );

  // serial output: marker then result, zeros shift in behind
  logic load_pending_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      shift_reg <= {(RES_BITS + 1){1'b0}};
      load_pending_reg <= 1'b0;
    end else if (ce) begin
      if (cs_s || state_reg != sac_pkg::SAC_READ) begin
        // a word popped outside readout is stale and dropped
        shift_reg <= {(RES_BITS + 1){1'b0}}; // [RL15] [RL18]
        load_pending_reg <= 1'b0;
      end else if (buf_pop && !load_pending_reg) begin
        shift_reg <= {1'b1, buf_out_data}; // [RL4]
        load_pending_reg <= 1'b1;
      end else if (sclk_fall && load_pending_reg) begin
        shift_reg <= {shift_reg[RES_BITS-1:0], 1'b0}; // [RL3] [RL17]
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      dout_o <= 1'b0;
      dout_oe <= 1'b0;
    end else if (ce) begin
      // a select fall in shutdown must not flash the driver for a cycle
      dout_oe <= !cs_s && (state_reg != sac_pkg::SAC_IDLE || (cs_fall && !shut)); // [RL2] [RL15] [RL6]
      dout_o <= !cs_s && shift_reg[RES_BITS];
    end
  end

  sva_tristate_a: assert property (@(posedge clk) disable iff (rst)
    ce && $past(ce) && $past(cs_s) && cs_s |-> !dout_oe) // [RL2]
    else $error("data output driven while select high");
  sva_start_hold_a: assert property (@(posedge clk) disable iff (rst)
    ce && cs_fall && !shut && state_reg == sac_pkg::SAC_IDLE ##1 ce && !cs_s |-> hold_o) // [RL1]
    else $error("conversion did not start on select fall");
  sva_no_shut_conv_a: assert property (@(posedge clk) disable iff (rst)
    ce && shut && state_reg == sac_pkg::SAC_IDLE |=> !hold_o) // [RL6]
    else $error("conversion started in shutdown");
  sva_sd_quiet_a: assert property (@(posedge clk) disable iff (rst)
    ce && shut && state_reg == sac_pkg::SAC_IDLE |=> !dout_oe) // [RL6]
    else $error("data output driven in shutdown");
  // held cycles counted here: the conversion is too long for a delay range
  logic [10:0] hold_cnt_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      hold_cnt_reg <= sac_pkg::SAC_CNT_RESET;
    end else if (ce) begin
      if (!hold_o) begin
        hold_cnt_reg <= sac_pkg::SAC_CNT_RESET;
      end else if (hold_cnt_reg != 11'h7ff) begin
        hold_cnt_reg <= hold_cnt_reg + 11'h001;
      end
    end
  end
  sva_conv_time_a: assert property (@(posedge clk) disable iff (rst)
    hold_cnt_reg <= 11'(sac_pkg::SAC_CONV_CYCLES)) // [RL9] [RL14]
    else $error("conversion exceeded its time");
  sva_marker_a: assert property (@(posedge clk) disable iff (rst)
    ce && $past(ce) && $past(ce, 2) && $past(state_reg) == sac_pkg::SAC_CONV && dout_oe |-> !dout_o) // [RL15]
    else $error("output high during conversion");
  sva_change_edge_a: assert property (@(posedge clk) disable iff (rst)
    ce && dout_oe && $past(dout_oe) && $changed(dout_o) |->
      $past(sclk_fall, 2) || $past(buf_pop, 2) || $past(cs_s)) // [RL3] [RL4]
    else $error("output changed without clock fall or marker");
  sva_ref_en_a: assert property (@(posedge clk) disable iff (rst)
    ce && $past(ce) && $past(ce, 2) && !$past(rst) && !$past(rst, 2) |->
      int_ref_en_o == ($past(pd_level_high, 2) && !$past(pd_level_low, 2))) // [RL8] [RL7]
    else $error("reference enabled wrongly");
  sva_abandon_a: assert property (@(posedge clk) disable iff (rst)
    ce && cs_s |=> state_reg == sac_pkg::SAC_IDLE) // [RL18]
    else $error("readout not abandoned on select rise");
  sva_trailing_a: assert property (@(posedge clk) disable iff (rst)
    ce && load_pending_reg && shift_reg == '0 && !cs_s && state_reg == sac_pkg::SAC_READ
      |=> shift_reg == '0) // [RL17]
    else $error("trailing bits not zero");
  sva_cov_conv_c: cover property (@(posedge clk) disable iff (rst) $fell(hold_o) && !cs_s);
  sva_cov_read_c: cover property (@(posedge clk) disable iff (rst) load_pending_reg && shift_reg == '0);
  sva_cov_abort_c: cover property (@(posedge clk) disable iff (rst) hold_o && cs_s);
endmodule // sac_top

// >>> sac_host.sv
// serial master model driving select and clock of the converter
module sac_host (
  input wire logic clk,
  input wire logic dout_pin,
  input wire logic dout_oe,
  output logic cs_n,
  output logic sclk
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] rx_reg;
  logic tmo;
  logic moved;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    tmo = 1'b0;
    moved = 1'b0;
  end
  task automatic start();
    @(posedge clk);
    sclk <= 1'b0;
    repeat (8) @(posedge clk); // clock low ahead of select fall
    cs_n <= 1'b0;
  endtask
  // clock still until the marker shows; the released pin may toggle, so enable is watched too
  task automatic readout(input int nfalls, input int slow);
    int i;
    rx_reg = 16'h0000;
    moved = 1'b0;
    i = 0;
    while (!(dout_oe === 1'b1 && dout_pin === 1'b1) && i < 1200) begin
      @(posedge clk);
      i++;
    end
    tmo = (i >= 1200);
    repeat (slow) @(posedge clk);
    for (i = 0; i < nfalls; i++) begin
      repeat (30) @(posedge clk); // 480 ns period, under 2.1 MHz
      rx_reg = {rx_reg[14:0], dout_pin};
      sclk <= 1'b1;
      repeat (30) @(posedge clk);
      if (dout_pin !== rx_reg[0]) moved = 1'b1;
      sclk <= 1'b0;
    end
  endtask
  task automatic stop();
    repeat (30) @(posedge clk);
    cs_n <= 1'b1;
    repeat (190) @(posedge clk); // acquisition before the next frame
  endtask
endmodule // sac_host

// >>> sac_top_tb.sv
// self-checking bench of the converter control block with a serial master model
module sac_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, ce, cs_n, sclk, pd_level_low, pd_level_high, cmp_in;
  logic dout_o, dout_oe, hold_o, shutdown_o, int_ref_en_o, float_reg, dout_pin;
  logic [9:0] dac_code_o;
  logic [9:0] v;
  int fail_count, cmp_count;
  int exp_q[$];
  sac_top sac_top_i (.clk(clk), .rst(rst), .ce(ce), .cs_n(cs_n), .sclk(sclk), .pd_level_low(pd_level_low),
    .pd_level_high(pd_level_high), .cmp_in(cmp_in), .dout_o(dout_o), .dout_oe(dout_oe), .hold_o(hold_o),
    .dac_code_o(dac_code_o), .shutdown_o(shutdown_o), .int_ref_en_o(int_ref_en_o));
  sac_host sac_host_i (.clk(clk), .dout_pin(dout_pin), .dout_oe(dout_oe), .cs_n(cs_n), .sclk(sclk));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // a released pin does not keep its last value
  always @(posedge clk) float_reg <= dout_oe ? ~dout_o : ~float_reg;
  assign dout_pin = dout_oe ? dout_o : float_reg;
  // ideal comparator against the held sample
  always @(posedge clk) cmp_in <= (v >= dac_code_o);
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic set_pd(input logic lo, input logic hi);
    @(posedge clk);
    pd_level_low <= lo;
    pd_level_high <= hi;
    repeat (4) @(posedge clk);
  endtask
  // one frame; short frames abandon readout early
  task automatic conv(input logic [9:0] val, input int nfalls, input int slow);
    @(posedge clk);
    v <= val;
    exp_q.push_back(int'(val));
    sac_host_i.start();
    repeat (6) @(posedge clk);
    check("hold", hold_o, 1'b1);
    check("oe_low", {dout_oe, dout_o}, 2'b10);
    sac_host_i.readout(nfalls, slow);
    check("timeout", sac_host_i.tmo, 1'b0);
    if (sac_host_i.tmo === 1'b1) end_sim();
    check("track", hold_o, 1'b0);
    check("moved", sac_host_i.moved, 1'b0);
    if (nfalls == 14) check("word", sac_host_i.rx_reg[13:0], {1'b1, 10'(exp_q.pop_front()), 3'b000});
    else void'(exp_q.pop_front());
    sac_host_i.stop();
    check("tristate", dout_oe, 1'b0);
  endtask
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    pd_level_low = 1'b0;
    pd_level_high = 1'b1;
    v = 10'h000;
    float_reg = 1'b0;
    cmp_in = 1'b0;
    fail_count = 0;
    cmp_count = 0;
    void'($urandom(81278));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("reset", {dout_oe, dout_o, hold_o, shutdown_o, int_ref_en_o}, 5'h00);
    // high, floating, then low
    for (int m = 2; m >= 0; m--) begin
      set_pd(m == 0, m == 2);
      check("shutdown", shutdown_o, 16'(m == 0));
      check("int_ref", int_ref_en_o, 16'(m == 2));
    end
    sac_host_i.start();
    repeat (10) @(posedge clk);
    check("sd_conv", {hold_o, dout_oe}, 2'b00);
    sac_host_i.stop();
    // high and floating both run; frame 3 abandons, frame 4 must start clean
    for (int k = 0; k < 8; k++) begin
      set_pd(1'b0, k[0]);
      conv(k == 0 ? 10'h000 : k == 1 ? 10'h3ff : 10'($urandom), k == 3 ? 3 : 14, k[1] ? 400 : 0);
    end
    // select falls while frozen: the start waits for the enable
    @(posedge clk);
    ce <= 1'b0;
    sac_host_i.start();
    repeat (10) @(posedge clk);
    check("freeze", {hold_o, dout_oe}, 2'b00);
    ce <= 1'b1;
    repeat (6) @(posedge clk);
    check("thaw", hold_o, 1'b1);
    sac_host_i.readout(14, 0);
    check("thaw_tmo", sac_host_i.tmo, 1'b0);
    check("thaw_word", sac_host_i.rx_reg[13:0], {1'b1, v, 3'b000});
    sac_host_i.stop();
    end_sim();
  end
endmodule // sac_top_tb
